// ===== design/spj_input_filter.sv
/*
 * spj_input_filter: holds the inputs until all nine are stable together for the filter time.
 * assumes inputs synchronous to mclk; filter time in ms set by filt_ms.
 */
module spj_input_filter (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] filt_ms,
    input wire logic [8:0] raw,
    output logic [8:0] clean
);
    logic [8:0] cand_r;
    logic [23:0] cnt_r;
    logic [23:0] limit;

    assign limit = 24'(filt_ms) * 24'(spj_pkg::FILT_UNIT_CYC);

    // restart the count on any change so a bounce never leaks through
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cand_r <= 9'h000;
            cnt_r <= 24'h00_0000;
            clean <= 9'h000;
        end else if (raw != cand_r) begin
            cand_r <= raw;
            cnt_r <= 24'h00_0000;
        end else if (cnt_r >= limit) begin
            clean <= cand_r;
        end else begin
            cnt_r <= cnt_r + 24'h00_0001;
        end
    end

    filter_delay_a: assert property (@(posedge mclk) disable iff (rst)
        $changed(clean) |-> $past(cnt_r) >= $past(limit))
        else $error("filtered input changed before filter time");
endmodule

// ===== design/spj_sequencer.sv
/*
 * spj_sequencer: program / jog mode selection and start sequencing.
 * assumes a motion profile generator consumes motion_cmd and returns
 * in_position; programs are loaded through the prog_wr port beforehand.
 */
// Summary of operation
// - command system defaults absolute; programs need it
// - direction digit sets program move sense
// - travel equals data times 1/10/100/1000
// - select input high gives program mode
// - five select lines choose the program
// - forward start runs the selected program
// - reverse start ignored in program mode
// - sync step with arg SYNC_ARG_ONE waits for program input; other args pass
// - speed and ramp steps set later moves
// - absolute move goes to scaled coordinate
// - inputs seen only after filter time
// - select low gives jog; selection ignored
// - jog uses jog speed and ramp parameters
// - direction digit sets jog rotation sense
// - reverse start jogs opposite to forward
module spj_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic forward_start_in,
    input wire logic reverse_start_in,
    input wire logic auto_manual_select,
    input wire logic prog_select_bit0,
    input wire logic prog_select_bit1,
    input wire logic prog_select_bit2,
    input wire logic prog_select_bit3,
    input wire logic prog_select_bit4,
    input wire logic program_sync_input,
    input wire logic [3:0] cmd_system_param,
    input wire logic [3:0] direction_param,
    input wire logic [1:0] feed_length_multiplier,
    input wire logic [7:0] filter_ms_param,
    input wire logic [15:0] jog_speed_param,
    input wire logic [15:0] jog_ramp_param,
    input wire logic in_position,
    input wire logic prog_wr,
    input wire logic [8:0] prog_wr_addr,
    input wire spj_pkg::spj_instr_t prog_wr_data,
    output spj_pkg::spj_motion_t motion_cmd,
    output logic program_mode,
    output logic program_busy,
    output logic sync_waiting,
    output logic cmd_system_error
);
    typedef enum logic [4:0] {
        SPJ_IDLE = 5'b00001,
        SPJ_FETCH = 5'b00010,
        SPJ_EXEC = 5'b00100,
        SPJ_MOVE = 5'b01000,
        SPJ_SYNC = 5'b10000
    } spj_state_t;

    spj_state_t state_r;
    logic [8:0] clean;
    logic fwd;
    logic rev;
    logic automode;
    logic sync_in;
    logic [4:0] sel;
    logic fwd_d_r;
    logic [4:0] prog_r;
    logic [3:0] step_r;
    spj_pkg::spj_instr_t instr_r;
    spj_pkg::spj_instr_t store [spj_pkg::NUM_PROGS * spj_pkg::NUM_STEPS];
    logic [15:0] prog_speed_r;
    logic [15:0] prog_ramp_r;
    logic abs_ok;

    // scale position data by 10^mult into micrometres
    function automatic logic signed [41:0] scale_pos(logic signed [31:0] d, logic [1:0] mult);
        logic signed [41:0] w;
        w = 42'(d);
        unique case (mult)
            2'h0: scale_pos = w;
            2'h1: scale_pos = 42'(w * 42'sd10);
            2'h2: scale_pos = 42'(w * 42'sd100);
            2'h3: scale_pos = 42'(w * 42'sd1000);
        endcase
    endfunction

    // direction digit 1 flips the sense of every start
    function automatic logic sense_ccw(logic positive, logic [3:0] dir);
        sense_ccw = (dir == spj_pkg::DIR_REVERSED) ? !positive : positive;
    endfunction

    spj_input_filter u_filter (
        .mclk(mclk),
        .rst(rst),
        .filt_ms(filter_ms_param),
        .raw({program_sync_input, prog_select_bit4, prog_select_bit3, prog_select_bit2,
              prog_select_bit1, prog_select_bit0, auto_manual_select, reverse_start_in,
              forward_start_in}),
        .clean(clean)
    );

    // filtered view of the controller's inputs
    assign fwd = clean[0];
    assign rev = clean[1];
    assign automode = clean[2];
    assign sel = clean[7:3];
    assign sync_in = clean[8];
    assign abs_ok = (cmd_system_param == spj_pkg::CMD_ABSOLUTE);

    // program store write port; contents are not reset
    always_ff @(posedge mclk) begin
        if (prog_wr) begin
            store[prog_wr_addr] <= prog_wr_data;
        end
    end

    // start edge detector, only a rising edge launches a program
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fwd_d_r <= 1'b0;
        end else begin
            fwd_d_r <= fwd;
        end
    end

    // program interpreter; leaving program mode aborts the program
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= SPJ_IDLE;
            prog_r <= 5'h00;
            step_r <= 4'h0;
            instr_r <= '0;
            prog_speed_r <= 16'h0000;
            prog_ramp_r <= 16'h0000;
        end else if (!automode) begin
            state_r <= SPJ_IDLE;
        end else begin
            unique case (state_r)
                SPJ_IDLE: begin
                    // reverse start plays no part here
                    if (fwd && !fwd_d_r && abs_ok) begin
                        prog_r <= sel;
                        step_r <= 4'h0;
                        state_r <= SPJ_FETCH;
                    end
                end
                SPJ_FETCH: begin
                    instr_r <= store[{prog_r, step_r}];
                    step_r <= step_r + 4'h1;
                    state_r <= SPJ_EXEC;
                end
                SPJ_EXEC: begin
                    unique case (instr_r.op)
                        spj_pkg::OP_SPEED: begin
                            prog_speed_r <= instr_r.arg[15:0];
                            state_r <= SPJ_FETCH;
                        end
                        spj_pkg::OP_RAMP: begin
                            prog_ramp_r <= instr_r.arg[15:0];
                            state_r <= SPJ_FETCH;
                        end
                        spj_pkg::OP_MOVE: state_r <= SPJ_MOVE;
                        spj_pkg::OP_SYNC: state_r <= SPJ_SYNC;
                        spj_pkg::OP_END: state_r <= SPJ_IDLE;
                        default: state_r <= SPJ_IDLE; // undefined op ends program
                    endcase
                end
                SPJ_MOVE: begin
                    // the command lands on the edge that enters this state, so only wait for arrival
                    if (in_position && motion_cmd.move) begin
                        state_r <= SPJ_FETCH;
                    end
                end
                SPJ_SYNC: begin
                    if (instr_r.arg[15:0] != spj_pkg::SYNC_ARG_ONE || sync_in) begin
                        state_r <= SPJ_FETCH;
                    end
                end
            endcase
        end
    end

    // motion command: program moves hold target, jog follows the starts
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            motion_cmd <= '0;
        end else if (automode) begin
            motion_cmd.speed <= prog_speed_r;
            motion_cmd.ramp <= prog_ramp_r;
            if (state_r == SPJ_EXEC && instr_r.op == spj_pkg::OP_MOVE) begin
                motion_cmd.run <= 1'b1;
                motion_cmd.move <= 1'b1;
                // target sign picks the rotation sense
                motion_cmd.ccw <= sense_ccw(!instr_r.arg[31], direction_param);
                motion_cmd.target <= scale_pos(instr_r.arg, feed_length_multiplier);
            end else if (state_r != SPJ_MOVE) begin
                motion_cmd.run <= 1'b0; // target stays put
                motion_cmd.move <= 1'b0;
            end
        end else begin
            motion_cmd.move <= 1'b0;
            motion_cmd.speed <= jog_speed_param;
            motion_cmd.ramp <= jog_ramp_param;
            // forward wins if both starts are held
            if (fwd) begin
                motion_cmd.run <= 1'b1;
                motion_cmd.ccw <= sense_ccw(1'b1, direction_param);
            end else if (rev) begin
                motion_cmd.run <= 1'b1;
                motion_cmd.ccw <= sense_ccw(1'b0, direction_param);
            end else begin
                motion_cmd.run <= 1'b0; // profile ramps down with jog ramp
            end
        end
    end

    // status flags
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            program_mode <= 1'b0;
            program_busy <= 1'b0;
            sync_waiting <= 1'b0;
            cmd_system_error <= 1'b0;
        end else begin
            program_mode <= automode;
            program_busy <= automode && state_r != SPJ_IDLE;
            sync_waiting <= automode && state_r == SPJ_SYNC;
            cmd_system_error <= automode && !abs_ok;
        end
    end

    // a refused start must be visible to the controller
    abs_only_a: assert property (@(posedge mclk) disable iff (rst)
        automode && !abs_ok |=> cmd_system_error)
        else $error("non-absolute command system not flagged");
    start_abs_a: assert property (@(posedge mclk) disable iff (rst)
        $past(state_r) == SPJ_IDLE && state_r == SPJ_FETCH |-> $past(abs_ok))
        else $error("program launched with non-absolute command system");
    prog_select_a: assert property (@(posedge mclk) disable iff (rst)
        state_r == SPJ_IDLE && automode && fwd && !fwd_d_r && abs_ok
        |=> prog_r == $past(sel))
        else $error("wrong program selected");
    rev_ignored_a: assert property (@(posedge mclk) disable iff (rst)
        state_r == SPJ_IDLE && automode && !(fwd && !fwd_d_r) |=> state_r == SPJ_IDLE)
        else $error("program started without forward start");
    sync_hold_a: assert property (@(posedge mclk) disable iff (rst)
        state_r == SPJ_SYNC && automode && !sync_in && instr_r.arg[15:0] == spj_pkg::SYNC_ARG_ONE
        |=> state_r == SPJ_SYNC)
        else $error("sync step left before program input");
    // the edge that releases reset still leaves the reset command in place
    jog_speed_a: assert property (@(posedge mclk) disable iff (rst)
        !automode && !$past(rst) |=> motion_cmd.speed == $past(jog_speed_param)
        && motion_cmd.ramp == $past(jog_ramp_param))
        else $error("jog not using jog parameters");
    jog_dir_a: assert property (@(posedge mclk) disable iff (rst)
        !automode && fwd |=> motion_cmd.run
        && motion_cmd.ccw == ($past(direction_param) != spj_pkg::DIR_REVERSED))
        else $error("jog forward direction wrong");
    jog_rev_a: assert property (@(posedge mclk) disable iff (rst)
        !automode && !fwd && rev |=> motion_cmd.run
        && motion_cmd.ccw == ($past(direction_param) == spj_pkg::DIR_REVERSED))
        else $error("jog reverse direction wrong");
    jog_release_a: assert property (@(posedge mclk) disable iff (rst)
        !automode && !fwd && !rev |=> !motion_cmd.run)
        else $error("jog run held after release");
    manual_idle_a: assert property (@(posedge mclk) disable iff (rst)
        !automode |=> state_r == SPJ_IDLE && !program_busy ##1 !program_busy)
        else $error("program active in manual mode");

    cover_jog_c: cover property (@(posedge mclk) disable iff (rst) !automode && rev ##1 motion_cmd.run);
    cover_prog_c: cover property (@(posedge mclk) disable iff (rst)
        state_r == SPJ_EXEC && instr_r.op == spj_pkg::OP_END);
    cover_sync_c: cover property (@(posedge mclk) disable iff (rst)
        state_r == SPJ_SYNC ##1 state_r == SPJ_FETCH);
endmodule

// ===== dv/spj_ctrl_model.sv
/*
 * spj_ctrl_model: external sequence controller that drives the discrete
 * mode, selection, start and sync inputs. assumes the bench calls its tasks
 * from one process; every output changes just after a rising mclk edge.
 */
module spj_ctrl_model #(
    parameter int LEAD_CYC = 4
) (
    input wire logic mclk,
    output logic fwd,
    output logic rev,
    output logic mode,
    output logic [4:0] sel,
    output logic sync
);
    timeunit 1ns;
    timeprecision 1ns;

    // all lines idle low until the first request
    initial begin
        fwd = 1'b0;
        rev = 1'b0;
        mode = 1'b0;
        sel = 5'h00;
        sync = 1'b0;
    end

    // selection settles well ahead of start, so filter delay and skew are covered
    task automatic start_prog(input logic [4:0] n);
        @(posedge mclk);
        sel <= n;
        repeat (LEAD_CYC) @(posedge mclk);
        fwd <= 1'b1;
    endtask

    // drive mode, both starts and sync together at one edge
    task automatic drive(input logic m, input logic f, input logic r, input logic s);
        @(posedge mclk);
        mode <= m;
        fwd <= f;
        rev <= r;
        sync <= s;
    endtask
endmodule

// ===== dv/testbench.sv
/*
 * testbench: program and jog scenarios for spj_sequencer.
 * assumes the controller model drives the discrete inputs; the bench plays
 * the profile generator by answering in_position after each positioning move.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ns;

    logic mclk, rst, in_position, prog_wr, fwd, rev, mode, sync;
    logic [3:0] cmd_system_param, direction_param;
    logic [1:0] feed_length_multiplier;
    logic [7:0] filter_ms_param;
    logic [4:0] sel;
    logic [8:0] prog_wr_addr;
    spj_pkg::spj_instr_t prog_wr_data;
    spj_pkg::spj_motion_t motion_cmd;
    logic program_mode, program_busy, sync_waiting, cmd_system_error;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    longint e;

    spj_ctrl_model ctrl_i (.mclk(mclk), .fwd(fwd), .rev(rev), .mode(mode), .sel(sel),
        .sync(sync));
    spj_sequencer spj_sequencer_i (.mclk(mclk), .rst(rst), .forward_start_in(fwd),
        .reverse_start_in(rev), .auto_manual_select(mode), .prog_select_bit0(sel[0]),
        .prog_select_bit1(sel[1]), .prog_select_bit2(sel[2]), .prog_select_bit3(sel[3]),
        .prog_select_bit4(sel[4]), .program_sync_input(sync),
        .cmd_system_param(cmd_system_param), .direction_param(direction_param),
        .feed_length_multiplier(feed_length_multiplier), .filter_ms_param(filter_ms_param),
        .jog_speed_param(16'h0123), .jog_ramp_param(16'h0045), .in_position(in_position),
        .prog_wr(prog_wr), .prog_wr_addr(prog_wr_addr), .prog_wr_data(prog_wr_data),
        .motion_cmd(motion_cmd), .program_mode(program_mode), .program_busy(program_busy),
        .sync_waiting(sync_waiting), .cmd_system_error(cmd_system_error));

    // 100 ns clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // hang guard: the longest test holds a start for about 1 ms
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            miscompares++;
            test_done();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t %s: saw %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // one program store write, prog_wr high for one cycle
    task automatic load(input logic [8:0] a, input logic [2:0] op, input logic [31:0] arg);
        @(posedge mclk);
        prog_wr <= 1'b1;
        prog_wr_addr <= a;
        prog_wr_data <= '{op: op, arg: arg};
        @(posedge mclk);
        prog_wr <= 1'b0;
    endtask

    // bounded waits; sampled after the edge so its updates have landed
    task automatic wait_run(input logic lvl, input int lim);
        for (int i = 0; i < lim && motion_cmd.run !== lvl; i++) @(negedge mclk);
    endtask

    task automatic wait_busy(input logic lvl);
        for (int i = 0; i < 200 && program_busy !== lvl; i++) @(negedge mclk);
    endtask

    // positioning move: check target and sense, then report arrival
    task automatic expect_move(input logic [63:0] tgt, input logic ccw);
        wait_run(1'b1, 200);
        check(64'(motion_cmd.target), tgt, "target");
        check(64'(motion_cmd.ccw), 64'(ccw), "sense");
        check(64'(motion_cmd.move), 64'h1, "move flag");
        @(posedge mclk);
        in_position <= 1'b1;
        wait_run(1'b0, 200);
        @(posedge mclk);
        in_position <= 1'b0;
        @(negedge mclk); // callers compare outputs, so leave them settled
    endtask

    initial begin
        rst = 1'b1;
        in_position = 1'b0;
        prog_wr = 1'b0;
        prog_wr_addr = 9'h000;
        prog_wr_data = '0;
        cmd_system_param = 4'h0;
        direction_param = 4'h0;
        feed_length_multiplier = 2'h1;
        filter_ms_param = 8'h00;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        check(64'(motion_cmd), 64'h0, "reset motion");
        check(64'(cmd_system_error), 64'h0, "reset cmd error");
        // program 1: speed, ramp, move, sync, ramp, move, end; program 2: move -3, end
        load(9'h010, spj_pkg::OP_SPEED, 32'h0000_03e8);
        load(9'h011, spj_pkg::OP_RAMP, 32'h0000_0064);
        load(9'h012, spj_pkg::OP_MOVE, 32'h0000_1388);
        load(9'h013, spj_pkg::OP_SYNC, 32'(spj_pkg::SYNC_ARG_ONE));
        load(9'h014, spj_pkg::OP_RAMP, 32'h0000_0032);
        load(9'h015, spj_pkg::OP_MOVE, 32'h0000_1d4c);
        load(9'h016, spj_pkg::OP_END, 32'h0000_0000);
        load(9'h020, spj_pkg::OP_MOVE, -32'sh0000_0003);
        load(9'h021, spj_pkg::OP_END, 32'h0000_0000);
        // program run with a sync hold between the two moves, x10 feed
        ctrl_i.drive(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge mclk);
        check(64'(program_mode), 64'h1, "program mode");
        ctrl_i.start_prog(5'h01);
        wait_busy(1'b1);
        check(64'(program_busy), 64'h1, "busy");
        expect_move(64'h0000_c350, 1'b1);
        check(64'(motion_cmd.speed), 64'h03e8, "speed");
        check(64'(motion_cmd.ramp), 64'h0064, "ramp");
        repeat (6) @(negedge mclk);
        check(64'(sync_waiting), 64'h1, "sync hold");
        check(64'(motion_cmd.run), 64'h0, "held still");
        ctrl_i.drive(1'b1, 1'b1, 1'b0, 1'b1);
        expect_move(64'h0001_24f8, 1'b1);
        check(64'(motion_cmd.ramp), 64'h0032, "second ramp");
        wait_busy(1'b0);
        check(64'(motion_cmd.target), 64'h0001_24f8, "target kept");
        check(64'(motion_cmd.run), 64'h0, "stopped at end");
        ctrl_i.drive(1'b1, 1'b0, 1'b0, 1'b0);
        $display("test program_sync done");
        // reverse start must not launch a program
        ctrl_i.drive(1'b1, 1'b0, 1'b1, 1'b0);
        repeat (12) @(negedge mclk);
        check(64'(program_busy), 64'h0, "reverse ignored");
        check(64'(motion_cmd.run), 64'h0, "reverse no run");
        ctrl_i.drive(1'b1, 1'b0, 1'b0, 1'b0);
        $display("test reverse_ignored done");
        // negative data through every feed factor and both direction senses
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                feed_length_multiplier <= 2'(m);
                direction_param <= d ? spj_pkg::DIR_REVERSED : spj_pkg::DIR_DEFAULT;
                e = -3;
                repeat (m) e = e * 10;
                ctrl_i.start_prog(5'h02);
                expect_move(64'(e), 1'(d));
                wait_busy(1'b0);
                ctrl_i.drive(1'b1, 1'b0, 1'b0, 1'b0);
                repeat (4) @(posedge mclk);
            end
        end
        $display("test feed_direction done");
        // a command system other than absolute refuses the start
        cmd_system_param <= 4'h1;
        ctrl_i.start_prog(5'h01);
        repeat (12) @(negedge mclk);
        check(64'(cmd_system_error), 64'h1, "cmd error");
        check(64'(program_busy), 64'h0, "no start");
        ctrl_i.drive(1'b1, 1'b0, 1'b0, 1'b0);
        cmd_system_param <= spj_pkg::CMD_ABSOLUTE;
        $display("test cmd_system done");
        // jog: both starts, both senses, selection left at program 1
        ctrl_i.drive(1'b0, 1'b0, 1'b0, 1'b0);
        repeat (4) @(negedge mclk);
        check(64'(program_mode), 64'h0, "jog mode");
        for (int d = 0; d < 2; d++) begin
            for (int r = 0; r < 2; r++) begin
                direction_param <= 4'(d);
                ctrl_i.drive(1'b0, 1'(r == 0), 1'(r), 1'b0);
                wait_run(1'b1, 50);
                check(64'(motion_cmd.move), 64'h0, "jog no move");
                check(64'(motion_cmd.speed), 64'h0123, "jog speed");
                check(64'(motion_cmd.ramp), 64'h0045, "jog ramp");
                check(64'(motion_cmd.ccw), 64'((d == 0) ^ (r == 1)), "jog sense");
                check(64'(program_busy), 64'h0, "jog no program");
                ctrl_i.drive(1'b0, 1'b0, 1'b0, 1'b0);
                wait_run(1'b0, 50);
                check(64'(motion_cmd.run), 64'h0, "jog stop");
            end
        end
        $display("test jog done");
        // a 1 ms filter: start is not seen early, but is seen once it has held
        filter_ms_param <= 8'h01;
        ctrl_i.drive(1'b0, 1'b1, 1'b0, 1'b0);
        repeat (9000) @(negedge mclk);
        check(64'(motion_cmd.run), 64'h0, "filtered early");
        wait_run(1'b1, 3000);
        check(64'(motion_cmd.run), 64'h1, "filtered late");
        ctrl_i.drive(1'b0, 1'b0, 1'b0, 1'b0);
        $display("test input_filter done");
        test_done();
    end
endmodule

// ===== include/spj_pkg.sv
/*
 * spj_pkg: constants and carrier types for the program / jog sequencer.
 * assumes a single 10 MHz control clock; parameters arrive as plain ports.
 */
package spj_pkg;
    // clock rate and derived timing
    localparam int CLK_HZ = 10_000_000;
    localparam int MS_CYC = CLK_HZ / 1000;          // cycles per millisecond
    localparam int FILT_UNIT_MS = 1;                // filter setting unit, ms
    localparam int FILT_UNIT_CYC = FILT_UNIT_MS * MS_CYC;
    // parameter encodings
    localparam logic [3:0] CMD_ABSOLUTE = 4'h0;     // command system default
    localparam logic [3:0] DIR_DEFAULT = 4'h0;
    localparam logic [3:0] DIR_REVERSED = 4'h1;
    localparam logic [1:0] FEED_MULT_DEFAULT = 2'h0; // x1
    // program store geometry
    localparam int PROG_BITS = 5;
    localparam int STEP_BITS = 4;
    localparam int NUM_PROGS = 32;
    localparam int NUM_STEPS = 16;
    // instruction opcodes
    localparam logic [2:0] OP_SPEED = 3'h1;
    localparam logic [2:0] OP_RAMP = 3'h2;
    localparam logic [2:0] OP_MOVE = 3'h3;
    localparam logic [2:0] OP_SYNC = 3'h4;
    localparam logic [2:0] OP_END = 3'h5;
    localparam logic [15:0] SYNC_ARG_ONE = 16'h0001;

    typedef struct packed {
        logic [2:0] op;
        logic signed [31:0] arg;
    } spj_instr_t;

    // motion command carried to the profile generator
    typedef struct packed {
        logic run;           // motor commanded
        logic ccw;           // rotation direction
        logic [15:0] speed;  // r/min
        logic [15:0] ramp;   // ms
        logic signed [41:0] target; // um, absolute
        logic move;          // positioning (1) or jog (0)
    } spj_motion_t;
endpackage
